// file: common/low_power_pkg.sv
package low_power_pkg;
    // register indices; the byte address is four times the index
    localparam logic [7:0] PWR_CTRL_IDX = 8'h87; // power control register
    localparam logic [7:0] MODE_STAT_IDX = 8'h88; // mode status register
    localparam int ADR_W = 10; // byte address width on the bus
    // field positions inside the power control register
    localparam int IDLE_BIT = 0; // idle request bit
    localparam int PD_BIT = 1; // power-down request bit
    localparam logic [7:0] PWR_CTRL_RST = 8'h00; // reset value
    localparam logic [7:0] PWR_CTRL_MASK = 8'hdf; // bit 5 reserved
    // field positions inside the mode status register
    localparam int STAT_IDLE_BIT = 0; // core sits in idle
    localparam int STAT_PD_BIT = 1; // core sits in power-down
    localparam int STAT_PEND_BIT = 2; // request waits for retire
    localparam int STAT_KBI_BIT = 3; // keypad level caught at entry

    // operating modes of the core
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_PEND,
        MODE_IDLE,
        MODE_PDOWN
    } mode_t;

    // wake sources from logic on the same clock
    typedef struct packed {
        logic enabled_irq; // any enabled interrupt pending
        logic ext_int_en; // external interrupt enable
        logic global_int_en; // global interrupt enable
        logic bod_irq; // brown-out interrupt
        logic wdt_irq; // watchdog interrupt
        logic kbi_en; // keypad interrupt enable
        logic hard_reset; // any reset other than software reset
    } wake_src_t;

    // clock and hold controls toward the clock generator
    typedef struct packed {
        logic cpu_clk_en; // cpu clock runs
        logic periph_clk_en; // peripheral clocks run
        logic flash_en; // flash memory active
        logic pins_hold; // port pins frozen at their levels
    } clk_ctl_t;
endpackage : low_power_pkg

// file: verilog/low_power_mode_control.sv
// Chosen here: the Wishbone slave port.
`timescale 1ns/10ps
module low_power_mode_control #(
    parameter int KBI_WIDTH = 8 // keypad pin count
) (
    input wire logic sys_clk, // 250 MHz system clock
    input wire logic nrst, // asynchronous reset, active low
    input wire logic cyc_i, // wishbone cycle
    input wire logic stb_i, // wishbone strobe
    input wire logic we_i, // wishbone write
    input wire logic [low_power_pkg::ADR_W-1:0] adr_i, // byte address
    input wire logic [31:0] dat_i, // write data
    input wire logic [3:0] sel_i, // byte selects
    output logic [31:0] dat_o, // read data
    output logic ack_o, // wishbone acknowledge
    input wire logic instr_retire, // core finished current instruction
    input wire low_power_pkg::wake_src_t wake_src, // same-clock sources
    input wire logic ext_int_pin, // external interrupt pin, async
    input wire logic [KBI_WIDTH-1:0] kbi_pin, // keypad pins, async
    output low_power_pkg::clk_ctl_t clk_ctl, // clock controls
    output logic fetch_en, // core may fetch instructions
    output logic wdt_clear, // one-cycle watchdog counter clear
    output logic wake_service, // one-cycle: take waking interrupt
    output logic core_reinit // one-cycle: restart from address zero
);

    ////////////////////////////////////////////////////////////////////////
    // parameter check at elaboration; the status view and the keypad
    // capture are sized for at most one byte of pins
    if (KBI_WIDTH < 1 || KBI_WIDTH > 8) begin : g_bad_width
        $error("KBI_WIDTH must lie between 1 and 8");
    end

    ////////////////////////////////////////////////////////////////////////
    // declarations
    low_power_pkg::mode_t mode; // current mode
    logic [7:0] power_control_reg; // software view of control bits
    logic [1:0] ext_sync; // external pin synchroniser
    logic [KBI_WIDTH-1:0] kbi_meta; // keypad first stage
    logic [KBI_WIDTH-1:0] kbi_sync; // keypad second stage
    logic [KBI_WIDTH-1:0] kbi_entry; // keypad levels at entry
    logic [KBI_WIDTH-1:0] kbi_edge; // per-pin opposite edge seen
    logic bus_req; // access presented on the bus
    logic wr_fire; // write takes effect this edge
    logic hit_ctrl; // control register addressed
    logic hit_stat; // status register addressed
    logic enter_req; // written byte asks for a low-power mode
    logic idle_wake; // a source ends idle
    logic pd_wake; // a source ends power-down
    logic go_low; // pending request now takes effect

    ////////////////////////////////////////////////////////////////////////
    // bus decode; the byte address is the index shifted by two
    assign bus_req = cyc_i & stb_i;
    assign wr_fire = bus_req & we_i & ack_o & sel_i[0];

    always_comb begin
        hit_ctrl = 1'b0;
        hit_stat = 1'b0;
        if (adr_i == {low_power_pkg::PWR_CTRL_IDX, 2'b00}) begin
            hit_ctrl = 1'b1; // power control register
        end else if (adr_i == {low_power_pkg::MODE_STAT_IDX, 2'b00}) begin
            hit_stat = 1'b1; // mode status register
        end
    end

    // write of one to either request bit starts a low-power entry
    assign enter_req = wr_fire & hit_ctrl &
        (dat_i[low_power_pkg::IDLE_BIT] | dat_i[low_power_pkg::PD_BIT]);

    // ack one cycle after the request, dropped the cycle after it was given
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= bus_req & ~ack_o;
        end
    end

    // read data is captured as ack rises; unmapped words read zero
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dat_o <= 32'h0000_0000;
        end else if (bus_req & ~ack_o) begin
            if (hit_ctrl) begin
                dat_o <= {24'h00_0000,
                    power_control_reg & low_power_pkg::PWR_CTRL_MASK};
            end else if (hit_stat) begin
                dat_o <= 32'h0000_0000;
                dat_o[low_power_pkg::STAT_IDLE_BIT] <=
                    (mode == low_power_pkg::MODE_IDLE);
                dat_o[low_power_pkg::STAT_PD_BIT] <=
                    (mode == low_power_pkg::MODE_PDOWN);
                dat_o[low_power_pkg::STAT_PEND_BIT] <=
                    (mode == low_power_pkg::MODE_PEND);
                dat_o[low_power_pkg::STAT_KBI_BIT] <= kbi_entry[0];
            end else begin
                dat_o <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; first stage feeds only the second
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ext_sync <= 2'b00;
            kbi_meta <= '0;
            kbi_sync <= '0;
        end else begin
            ext_sync <= {ext_sync[0], ext_int_pin};
            kbi_meta <= kbi_pin;
            kbi_sync <= kbi_meta;
        end
    end

    // keypad level caught as idle or power-down begins, so the wake edge is known
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            kbi_entry <= '0;
        end else if (go_low) begin
            kbi_entry <= kbi_sync;
        end
    end

    // per pin: low at entry wakes on rise, high at entry wakes on fall
    for (genvar k = 0; k < KBI_WIDTH; k++) begin : g_kbi
        assign kbi_edge[k] = kbi_sync[k] ^ kbi_entry[k];
    end

    ////////////////////////////////////////////////////////////////////////
    // wake conditions
    // peripherals keep clocking in idle, so any enabled interrupt ends it
    assign idle_wake = wake_src.enabled_irq |
        wake_src.hard_reset;

    // in power-down only pin, brown-out, watchdog, keypad or reset wake;
    // the pin is honoured only with its own and the global enable
    assign pd_wake = (ext_sync[1] & wake_src.ext_int_en &
        wake_src.global_int_en) |
        wake_src.bod_irq | wake_src.wdt_irq |
        (wake_src.kbi_en & (|kbi_edge)) |
        wake_src.hard_reset;

    // entry only once the writing instruction has retired
    assign go_low = (mode == low_power_pkg::MODE_PEND) & instr_retire;

    ////////////////////////////////////////////////////////////////////////
    // mode sequencer
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mode <= low_power_pkg::MODE_RUN;
        end else begin
            case (mode)
                low_power_pkg::MODE_RUN: begin
                    if (enter_req) begin
                        mode <= low_power_pkg::MODE_PEND;
                    end
                end
                low_power_pkg::MODE_PEND: begin
                    if (instr_retire) begin
                        // power-down wins when both bits are set
                        if (power_control_reg[low_power_pkg::PD_BIT]) begin
                            mode <= low_power_pkg::MODE_PDOWN;
                        end else begin
                            mode <= low_power_pkg::MODE_IDLE;
                        end
                    end
                end
                low_power_pkg::MODE_IDLE: begin
                    if (idle_wake) begin
                        mode <= low_power_pkg::MODE_RUN;
                    end
                end
                low_power_pkg::MODE_PDOWN: begin
                    // back to run, never to idle
                    if (pd_wake) begin
                        mode <= low_power_pkg::MODE_RUN;
                    end
                end
                default: begin
                    mode <= low_power_pkg::MODE_RUN;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power control register; hardware clears the request bits on wake.
    // the core is stopped while a mode lasts, so no write meets a clear.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            power_control_reg <= low_power_pkg::PWR_CTRL_RST;
        end else if (mode == low_power_pkg::MODE_PDOWN && pd_wake) begin
            power_control_reg[low_power_pkg::PD_BIT] <= 1'b0;
            power_control_reg[low_power_pkg::IDLE_BIT] <= 1'b0;
        end else if (mode == low_power_pkg::MODE_IDLE && idle_wake) begin
            power_control_reg[low_power_pkg::IDLE_BIT] <= 1'b0;
        end else if (wr_fire && hit_ctrl) begin
            power_control_reg <= dat_i[7:0] & low_power_pkg::PWR_CTRL_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event pulses toward watchdog and core
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wdt_clear <= 1'b0;
            wake_service <= 1'b0;
            core_reinit <= 1'b0;
        end else begin
            // cleared both on entry and on wake, so no stray timeout
            wdt_clear <= go_low |
                (mode == low_power_pkg::MODE_IDLE && idle_wake) |
                (mode == low_power_pkg::MODE_PDOWN && pd_wake);
            // a reset wake restarts the core instead of servicing
            wake_service <= ~wake_src.hard_reset &
                ((mode == low_power_pkg::MODE_IDLE && idle_wake) |
                (mode == low_power_pkg::MODE_PDOWN && pd_wake));
            core_reinit <= wake_src.hard_reset &
                (mode == low_power_pkg::MODE_IDLE ||
                mode == low_power_pkg::MODE_PDOWN);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock controls; cpu clock drops in the very retire cycle so the
    // next instruction cannot start
    always_comb begin
        clk_ctl.cpu_clk_en = (mode == low_power_pkg::MODE_RUN) |
            ((mode == low_power_pkg::MODE_PEND) & ~instr_retire);
        clk_ctl.periph_clk_en = (mode != low_power_pkg::MODE_PDOWN);
        clk_ctl.flash_en = (mode != low_power_pkg::MODE_PDOWN);
        clk_ctl.pins_hold = (mode == low_power_pkg::MODE_IDLE) |
            (mode == low_power_pkg::MODE_PDOWN);
        fetch_en = clk_ctl.cpu_clk_en;
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    AST_ENTRY_WAITS:
        assert property (@(posedge sys_clk) disable iff (!nrst)
        mode == low_power_pkg::MODE_PEND && !instr_retire
        |=> mode == low_power_pkg::MODE_PEND)
        else $error("low-power entry before retire");

    AST_IDLE_ENTRY:
        assert property (@(posedge sys_clk) disable iff (!nrst)
        go_low && !power_control_reg[low_power_pkg::PD_BIT]
        |=> mode == low_power_pkg::MODE_IDLE && !clk_ctl.cpu_clk_en
        && clk_ctl.periph_clk_en)
        else $error("idle entry wrong");

    AST_PD_WINS:
        assert property (@(posedge sys_clk) disable iff (!nrst)
        go_low && power_control_reg[low_power_pkg::PD_BIT]
        |=> mode == low_power_pkg::MODE_PDOWN && !clk_ctl.periph_clk_en
        && !clk_ctl.flash_en)
        else $error("power-down entry wrong");

    // a second clear right after entry is only legal as an immediate wake
    AST_WDT_ON_ENTRY:
        assert property (@(posedge sys_clk) disable iff (!nrst)
        go_low |=> wdt_clear
        ##1 (!wdt_clear || wake_service || core_reinit))
        else $error("watchdog not cleared on entry");

    AST_IDLE_WAKE:
        assert property (@(posedge sys_clk) disable iff (!nrst)
        mode == low_power_pkg::MODE_IDLE && wake_src.enabled_irq
        && !wake_src.hard_reset
        |=> mode == low_power_pkg::MODE_RUN && wake_service && wdt_clear
        && !power_control_reg[low_power_pkg::IDLE_BIT])
        else $error("idle wake wrong");

    AST_PD_WAKE_CLEARS:
        assert property (@(posedge sys_clk)
        disable iff (!nrst)
        mode == low_power_pkg::MODE_PDOWN && pd_wake
        |=> mode == low_power_pkg::MODE_RUN
        && power_control_reg[1:0] == 2'b00)
        else $error("power-down wake left bits set");

    AST_PIN_NEEDS_EN:
        assert property (@(posedge sys_clk) disable iff (!nrst)
        mode == low_power_pkg::MODE_PDOWN && !wake_src.global_int_en
        && !wake_src.bod_irq && !wake_src.wdt_irq && !wake_src.hard_reset
        && !(wake_src.kbi_en && |kbi_edge)
        |=> mode == low_power_pkg::MODE_PDOWN)
        else $error("pin woke without global enable");

    AST_RESET_WAKE:
        assert property (@(posedge sys_clk) disable iff (!nrst)
        (mode == low_power_pkg::MODE_PDOWN ||
        mode == low_power_pkg::MODE_IDLE) && wake_src.hard_reset
        |=> core_reinit && !wake_service
        && mode == low_power_pkg::MODE_RUN)
        else $error("reset did not end low-power mode");

    AST_KBI_EDGE:
        assert property (@(posedge sys_clk) disable iff (!nrst)
        mode == low_power_pkg::MODE_PDOWN && wake_src.kbi_en
        && $changed(kbi_sync[0]) && kbi_sync[0] != kbi_entry[0]
        |=> mode == low_power_pkg::MODE_RUN)
        else $error("keypad edge did not wake");

    AST_HOLD_PINS:
        assert property (@(posedge sys_clk) disable iff (!nrst)
        mode == low_power_pkg::MODE_IDLE
        |-> clk_ctl.pins_hold && !fetch_en)
        else $error("pins or fetch not frozen");

    COV_IDLE_CYCLE: cover property (@(posedge sys_clk) disable iff (!nrst)
        mode == low_power_pkg::MODE_IDLE ##1 mode == low_power_pkg::MODE_RUN);
    COV_PD_PIN: cover property (@(posedge sys_clk) disable iff (!nrst)
        mode == low_power_pkg::MODE_PDOWN && ext_sync[1]
        && wake_src.ext_int_en && wake_src.global_int_en);
    COV_PD_KBI: cover property (@(posedge sys_clk) disable iff (!nrst)
        mode == low_power_pkg::MODE_PDOWN && wake_src.kbi_en && |kbi_edge);
    COV_RESET_WAKE: cover property (@(posedge sys_clk) disable iff (!nrst)
        core_reinit);

    // the retire cycle already stops the cpu clock, so nothing follows
    AST_RETIRE_STOPS:
        assert property (@(posedge sys_clk) disable iff (!nrst)
        go_low |-> !clk_ctl.cpu_clk_en && !fetch_en)
        else $error("cpu clock ran in retire cycle");

    // power-down stops every clock and the flash; pins keep their levels
    AST_PD_CLOCKS:
        assert property (@(posedge sys_clk) disable iff (!nrst)
        mode == low_power_pkg::MODE_PDOWN |-> !clk_ctl.cpu_clk_en
        && !clk_ctl.periph_clk_en && !clk_ctl.flash_en
        && clk_ctl.pins_hold)
        else $error("power-down clocks wrong");

    // idle stops only the cpu; timers and serial port keep clocking
    AST_IDLE_CLOCKS:
        assert property (@(posedge sys_clk) disable iff (!nrst)
        mode == low_power_pkg::MODE_IDLE |-> !clk_ctl.cpu_clk_en
        && clk_ctl.periph_clk_en && clk_ctl.flash_en)
        else $error("idle clocks wrong");

    // every wake clears the watchdog counter, so no stray timeout follows
    AST_WDT_ON_WAKE:
        assert property (@(posedge sys_clk) disable iff (!nrst)
        ((mode == low_power_pkg::MODE_IDLE && idle_wake) ||
        (mode == low_power_pkg::MODE_PDOWN && pd_wake))
        |=> wdt_clear)
        else $error("watchdog not cleared on wake");

    // an enabled interrupt alone never ends power-down
    AST_PD_IGNORES_IRQ:
        assert property (@(posedge sys_clk) disable iff (!nrst)
        mode == low_power_pkg::MODE_PDOWN && wake_src.enabled_irq
        && !ext_sync[1] && !wake_src.bod_irq && !wake_src.wdt_irq
        && !wake_src.hard_reset && !(wake_src.kbi_en && |kbi_edge)
        |=> mode == low_power_pkg::MODE_PDOWN)
        else $error("interrupt ended power-down");

    // keypad levels are caught at the entry edge
    AST_KBI_CAPTURE:
        assert property (@(posedge sys_clk) disable iff (!nrst)
        go_low |=> kbi_entry == $past(kbi_sync))
        else $error("keypad entry level not caught");

    // the service pulse only follows a wake from a low-power mode
    AST_SERVICE_ON_WAKE:
        assert property (@(posedge sys_clk) disable iff (!nrst)
        wake_service |-> $past(mode) != low_power_pkg::MODE_RUN
        && mode == low_power_pkg::MODE_RUN)
        else $error("service pulse without wake");

endmodule : low_power_mode_control

// file: tb/core_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
// stand-in for the cpu core: retires one instruction every few cycles
module core_model (
    input wire logic sys_clk, // system clock
    input wire logic nrst, // reset, active low
    input wire logic fetch_en, // core clock runs
    input wire logic slow, // long instructions
    output logic instr_retire // instruction completed
);
    logic [3:0] cnt; // cycles into the current instruction
    // registered on purpose: a combinational retire would loop through
    // the gated cpu clock enable
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 4'h0;
            instr_retire <= 1'b0;
        end else if (fetch_en) begin
            cnt <= cnt + 4'h1;
            instr_retire <= slow ? (cnt == 4'hf) : (cnt[1:0] == 2'h3);
        end else begin
            instr_retire <= 1'b0; // a stopped core retires nothing
        end
    end
endmodule : core_model

// file: tb/tb.sv
`timescale 1ns/10ps
module tb;
    logic sys_clk = 1'b0; // 250 MHz system clock
    logic nrst = 1'b0; // reset, active low
    logic cyc = 1'b0; // bus cycle
    logic stb = 1'b0; // bus strobe
    logic we = 1'b0; // bus write
    logic [3:0] sel = 4'h0; // byte selects
    logic [low_power_pkg::ADR_W-1:0] adr = '0; // byte address
    logic [31:0] dat = 32'h0; // write data
    logic [31:0] dat_o; // read data
    logic ack_o, instr_retire, fetch_en, wdt_clear, wake_service;
    logic core_reinit; // reset woke the core
    logic ext_pin = 1'b0; // external interrupt pin
    logic slow = 1'b0; // core model speed
    logic [7:0] keypad_interrupt = 8'h00; // keypad pins
    low_power_pkg::wake_src_t ws = '0; // same-clock wake sources
    low_power_pkg::clk_ctl_t clk_ctl; // clock controls
    logic [31:0] rq[$]; // expected read data
    logic [2:0] wq[$]; // expected wake, reinit, clear pulses
    int num_errors = 0;
    int tests_run = 0;

    always #2 sys_clk = ~sys_clk;

    low_power_mode_control #(.KBI_WIDTH(8)) u_dut (.sys_clk(sys_clk),
        .nrst(nrst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .dat_i(dat), .sel_i(sel), .dat_o(dat_o), .ack_o(ack_o),
        .instr_retire(instr_retire), .wake_src(ws), .ext_int_pin(ext_pin),
        .kbi_pin(keypad_interrupt), .clk_ctl(clk_ctl), .fetch_en(fetch_en),
        .wdt_clear(wdt_clear), .wake_service(wake_service),
        .core_reinit(core_reinit));
    core_model u_core (.sys_clk(sys_clk), .nrst(nrst), .fetch_en(fetch_en),
        .slow(slow), .instr_retire(instr_retire));

    ////////////////////////////////////////////////////////////////////
    task fail(input string m);
        num_errors++;
        $display("[ERR] %0t %s", $time, m);
    endtask : fail
    task chk(input logic [31:0] g, input logic [31:0] e, input string m);
        tests_run++;
        if (g !== e) fail(m);
    endtask : chk
    task test_done;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done
    // classic single cycle; held until ack is sampled, then released
    task wb(input logic w, input logic [7:0] i, input logic [7:0] d,
            input logic [7:0] e, input logic [3:0] s);
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= s;
        adr <= {i, 2'b00};
        dat <= {24'h0, d};
        if (!w) rq.push_back({24'h0, e});
        // no timeout of its own: the wait ends on ack, or through the bench watchdog if ack never comes
        do begin
            @(posedge sys_clk);
        end while (ack_o !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    // write a request and wait for the core to stop
    task sleep(input logic [7:0] v, input logic [3:0] c);
        wb(1'b1, 8'h87, v, 8'h00, 4'h1);
        do begin
            @(posedge sys_clk);
        end while (fetch_en !== 1'b0);
        @(posedge sys_clk);
        chk({31'h0, wdt_clear}, 32'h1, "entry clear");
        chk({28'h0, clk_ctl}, {28'h0, c}, "gating");
    endtask : sleep
    // raise one wake source for four cycles, or flip one keypad pin and keep it
    task poke(input int s);
        @(posedge sys_clk);
        case (s)
            0: ws.wdt_irq <= 1'b1;
            1: ws.bod_irq <= 1'b1; // raised only after the core is asleep
            2: ext_pin <= 1'b1;
            3: keypad_interrupt <= keypad_interrupt ^ (8'h01 << $urandom_range(7));
            4: ws.hard_reset <= 1'b1;
            default: ws.enabled_irq <= 1'b1;
        endcase
        repeat (4) @(posedge sys_clk);
        ws <= ws & 7'h32; // keep only the enables
        ext_pin <= 1'b0;
    endtask : poke
    task wait_run;
        repeat (2) @(posedge sys_clk);
        chk({31'h0, fetch_en}, 32'h1, "resume");
    endtask : wait_run
    task asleep;
        chk({31'h0, fetch_en}, 32'h0, "woke wrongly");
    endtask : asleep

    ////////////////////////////////////////////////////////////////////
    // scoreboard: oldest note against each result that appears
    always @(posedge sys_clk) begin
        if (ack_o === 1'b1 && we === 1'b0 && rq.size() > 0)
            chk(dat_o, rq.pop_front(), "read data");
        if ((wake_service | core_reinit) === 1'b1) begin
            if (wq.size() == 0) fail("stray wake");
            else chk({29'h0, wake_service, core_reinit, wdt_clear},
                     {29'h0, wq.pop_front()}, "wake pulses");
        end
    end
    // a hang ends the run as a mismatch
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail("watchdog");
        test_done;
    end

    initial begin
        void'($urandom(32'h89c7));
        keypad_interrupt <= 8'($urandom());
        slow <= 1'($urandom_range(1));
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        chk({28'h0, clk_ctl}, 32'he, "run clocks");
        wb(1'b0, 8'h87, 8'h00, 8'h00, 4'h1);
        wb(1'b0, 8'h88, 8'h00, 8'h00, 4'h1);
        $display("test 1 done");
        wb(1'b1, 8'h87, 8'hfc, 8'h00, 4'h1);
        wb(1'b1, 8'h87, 8'h00, 8'h00, 4'h0); // no byte select: dropped
        wb(1'b0, 8'h87, 8'h00, 8'hdc, 4'h1);
        wb(1'b1, 8'h40, 8'hff, 8'h00, 4'h1);
        wb(1'b0, 8'h40, 8'h00, 8'h00, 4'h1);
        wb(1'b1, 8'h88, 8'hff, 8'h00, 4'h1);
        wb(1'b0, 8'h88, 8'h00, 8'h00, 4'h1);
        $display("test 2 done");
        sleep(8'hdd, 4'b0111);
        wb(1'b0, 8'h88, 8'h00, {4'h0, keypad_interrupt[0], 3'b001}, 4'h1);
        for (int s = 0; s < 3; s++) poke(s);
        asleep;
        wq.push_back(3'b101);
        poke(5);
        wait_run;
        wb(1'b0, 8'h87, 8'h00, 8'hdc, 4'h1);
        $display("test 3 done");
        sleep(8'h01, 4'b0111);
        wq.push_back(3'b011);
        poke(4);
        wait_run;
        wb(1'b0, 8'h87, 8'h00, 8'h00, 4'h1);
        $display("test 4 done");
        ws.ext_int_en <= 1'b1;
        sleep(8'hdf, 4'b0001);
        poke(5);
        poke(2);
        asleep;
        wb(1'b0, 8'h88, 8'h00, {4'h0, keypad_interrupt[0], 3'b010}, 4'h1);
        ws.global_int_en <= 1'b1;
        wq.push_back(3'b101);
        poke(2);
        wait_run;
        wb(1'b0, 8'h87, 8'h00, 8'hdc, 4'h1);
        repeat (8) @(posedge sys_clk);
        chk({28'h0, clk_ctl}, 32'he, "no idle after");
        $display("test 5 done");
        for (int k = 0; k < 4; k++) begin
            int s;
            s = (k < 2) ? k : k + 1;
            ws.kbi_en <= (s == 3);
            sleep(8'h02, 4'b0001);
            wq.push_back((s == 4) ? 3'b011 : 3'b101);
            poke(s);
            wait_run;
            wb(1'b0, 8'h87, 8'h00, 8'h00, 4'h1);
        end
        $display("test 6 done");
        test_done;
    end
endmodule : tb
